// >>> arf_defs.vh
// Purpose: constants for the upper source-node request filter
// Assumes: AXI4-Lite register access, 32-bit data, byte addresses
// Notes: Function list of the block follows
// Function
// - Bits 30..0 map nodes 62..32
// - Bit 0 enables node 32
// - Bit 31 accepts all remote buses
// - Remote bus requests unacknowledged unless bit 31
// - Check source ID of physical/receive requests
// - Cleared bit: no acknowledge, no queueing
// - Per-node compare only for local bus
// - Set view and following clear view
// - Filter resets to all zeros
`ifndef ARF_DEFS_VH
`define ARF_DEFS_VH
// ==========================================================
// Register map
`define ARF_OFS_FILTER_SET 12'h100
`define ARF_OFS_FILTER_CLEAR 12'h104
`define ARF_OFS_STATUS 12'h108
`define ARF_FILTER_RESET 32'h00000000
// ==========================================================
// Field layout
`define ARF_BIT_ALL_BUSES 31
`define ARF_NODE_BASE 6'h20
`define ARF_NODE_TOP 6'h3E
`define ARF_LOCAL_BUS 10'h3FF
`define ARF_RESP_OKAY 2'h0
`define ARF_RESP_SLVERR 2'h2
`endif

// >>> arf_regs.v
// Purpose: filter register with set and clear views
// Assumes: strobes are single-cycle, same clock
// Notes: set wins when set and clear hit the same bit
`timescale 1ns/1ps
`default_nettype none
`include "arf_defs.vh"
module arf_regs #(
    parameter WIDTH = 32
) (
    input wire aclk,
    input wire aresetn,
    input wire set_stb,
    input wire clr_stb,
    input wire [WIDTH-1:0] wdata,
    input wire [3:0] wstrb,
    output reg [WIDTH-1:0] filter
);
    // ==========================================================
    // Byte-lane masks
    wire [WIDTH-1:0] lane_mask;
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_lane
            assign lane_mask[i] = wstrb[i/8];
        end
    endgenerate
    wire [WIDTH-1:0] set_bits = set_stb ? (wdata & lane_mask) : {WIDTH{1'b0}};
    wire [WIDTH-1:0] clr_bits = clr_stb ? (wdata & lane_mask) : {WIDTH{1'b0}};
    // Filter storage
    always @(posedge aclk) begin
        if (!aresetn) begin
            filter <= `ARF_FILTER_RESET;
        end else begin
            filter <= (filter & ~clr_bits) | set_bits;
        end
    end
endmodule
`default_nettype wire

// >>> arf_match.v
// Purpose: decides acceptance of one request source
// Assumes: source bus and node from the packet header
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "arf_defs.vh"
module arf_match (
    input wire [31:0] filter,
    input wire [9:0] src_bus,
    input wire [5:0] src_node,
    input wire [9:0] local_bus,
    output reg accept,
    output reg in_range
);
    reg is_local;
    reg [5:0] idx;
    // Local compare or remote-bus enable
    always @* begin
        is_local = (src_bus == `ARF_LOCAL_BUS) || (src_bus == local_bus);
        idx = src_node - `ARF_NODE_BASE;
        in_range = 1'b1;
        accept = 1'b0;
        if (!is_local) begin
            accept = filter[`ARF_BIT_ALL_BUSES];
        end else if (src_node >= `ARF_NODE_BASE && src_node <= `ARF_NODE_TOP) begin
            accept = filter[idx[4:0]];
        end else begin
            in_range = 1'b0;
        end
    end
endmodule
`default_nettype wire

// >>> arf_top.v
// Purpose: upper source-node request filter with AXI4-Lite access
// Assumes: request strobe and header fields come from same-clock logic
// Notes: answer is registered one cycle after the request
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "arf_defs.vh"
module arf_top (
    input wire aclk,
    input wire aresetn,
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire [9:0] local_bus,
    input wire req_valid,
    input wire req_to_physical,
    input wire [9:0] req_src_bus,
    input wire [5:0] req_src_node,
    output reg chk_valid,
    output reg chk_accept,
    output reg chk_ack,
    output reg chk_queue,
    output reg chk_in_range
);
    // ==========================================================
    // Write channel capture
    reg aw_held;
    reg [11:0] aw_addr;
    reg w_held;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    wire [31:0] filter;
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire have_aw = aw_held || aw_take;
    wire have_w = w_held || w_take;
    wire [11:0] cur_awaddr = aw_held ? aw_addr : s_axi_awaddr;
    wire [31:0] cur_wdata = w_held ? w_data : s_axi_wdata;
    wire [3:0] cur_wstrb = w_held ? w_strb : s_axi_wstrb;
    wire do_write = have_aw && have_w && !s_axi_bvalid;
    reg set_stb;
    reg clr_stb;
    reg wr_ok;
    // Write address decode
    always @* begin
        set_stb = 1'b0;
        clr_stb = 1'b0;
        wr_ok = 1'b1;
        if ({cur_awaddr[11:2], 2'h0} == `ARF_OFS_FILTER_SET) begin
            set_stb = do_write;
        end else if ({cur_awaddr[11:2], 2'h0} == `ARF_OFS_FILTER_CLEAR) begin
            clr_stb = do_write;
        end else begin
            wr_ok = 1'b0;
        end
    end
    // Holding and response
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 12'h000;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `ARF_RESP_OKAY;
        end else begin
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? `ARF_RESP_OKAY : `ARF_RESP_SLVERR;
            end else begin
                if (aw_take) begin
                    aw_held <= 1'b1;
                    aw_addr <= s_axi_awaddr;
                end
                if (w_take) begin
                    w_held <= 1'b1;
                    w_data <= s_axi_wdata;
                    w_strb <= s_axi_wstrb;
                end
                if (s_axi_bvalid && s_axi_bready) begin
                    s_axi_bvalid <= 1'b0;
                end
            end
        end
    end
    // ==========================================================
    // Filter storage
    arf_regs #(.WIDTH(32)) u_regs (
        .aclk(aclk),
        .aresetn(aresetn),
        .set_stb(set_stb),
        .clr_stb(clr_stb),
        .wdata(cur_wdata),
        .wstrb(cur_wstrb),
        .filter(filter)
    );
    // ==========================================================
    // Read channel
    reg [9:0] rej_count;
    assign s_axi_arready = !s_axi_rvalid;
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `ARF_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `ARF_RESP_OKAY;
            if ({s_axi_araddr[11:2], 2'h0} == `ARF_OFS_FILTER_SET) begin
                s_axi_rdata <= filter;
            end else if ({s_axi_araddr[11:2], 2'h0} == `ARF_OFS_FILTER_CLEAR) begin
                s_axi_rdata <= filter;
            end else if ({s_axi_araddr[11:2], 2'h0} == `ARF_OFS_STATUS) begin
                s_axi_rdata <= {22'h000000, rej_count};
            end else begin
                s_axi_rdata <= 32'h00000000;
                s_axi_rresp <= `ARF_RESP_SLVERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
    // ==========================================================
    // Request check
    wire m_accept;
    wire m_in_range;
    arf_match u_match (
        .filter(filter),
        .src_bus(req_src_bus),
        .src_node(req_src_node),
        .local_bus(local_bus),
        .accept(m_accept),
        .in_range(m_in_range)
    );
    // Verdict for each request, one cycle later
    always @(posedge aclk) begin
        if (!aresetn) begin
            chk_valid <= 1'b0;
            chk_accept <= 1'b0;
            chk_ack <= 1'b0;
            chk_queue <= 1'b0;
            chk_in_range <= 1'b0;
            rej_count <= 10'h000;
        end else begin
            chk_valid <= req_valid;
            chk_accept <= req_valid && m_accept;
            chk_ack <= req_valid && m_accept;
            chk_queue <= req_valid && m_accept;
            chk_in_range <= req_valid && m_in_range;
            if (req_valid && m_in_range && !m_accept && rej_count != 10'h3FF) begin
                rej_count <= rej_count + 10'h001;
            end
        end
    end
endmodule
`default_nettype wire

// >>> arf_checker.sv
// Purpose: port assertions of the upper request filter
// Assumes: one clock, synchronous active-low reset
// Notes: bound to the top module below
`timescale 1ns/1ps
`default_nettype none
module arf_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [9:0] local_bus,
    input wire logic req_valid,
    input wire logic [9:0] req_src_bus,
    input wire logic [5:0] req_src_node,
    input wire logic chk_valid,
    input wire logic chk_accept,
    input wire logic chk_ack,
    input wire logic chk_queue,
    input wire logic chk_in_range
);
    // ====================
    // Verdict timing and scope
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_local;
        req_valid && (req_src_bus == 10'h3FF || req_src_bus == local_bus);
    endsequence
    chk_req_taken: assert property (req_valid |=> chk_valid) else $error("no verdict");
    chk_no_extra: assert property (!req_valid |=> !chk_valid) else $error("stray verdict");
    chk_ack_pair: assert property (chk_ack == chk_accept && chk_queue == chk_accept) else $error("ack split");
    chk_idle_quiet: assert property (!chk_valid |-> !chk_accept && !chk_in_range) else $error("idle verdict");
    chk_accept_scope: assert property (chk_accept |-> chk_in_range) else $error("accept out of scope");
    chk_low_nodes: assert property (s_local ##0 req_src_node < 6'h20 |=> !chk_in_range) else $error("low node");
    chk_node_top: assert property (s_local ##0 req_src_node == 6'h3F |=> !chk_accept) else $error("node 63");
    chk_remote_scope: assert property (req_valid && req_src_bus != 10'h3FF && req_src_bus != local_bus
        |=> chk_in_range) else $error("remote out of scope");
endmodule
bind arf_top arf_checker u_chk (.aclk(aclk), .aresetn(aresetn), .local_bus(local_bus), .req_valid(req_valid),
    .req_src_bus(req_src_bus), .req_src_node(req_src_node), .chk_valid(chk_valid), .chk_accept(chk_accept),
    .chk_ack(chk_ack), .chk_queue(chk_queue), .chk_in_range(chk_in_range));
`default_nettype wire

// >>> arf_node_model.sv
// Purpose: remote nodes sending request headers
// Assumes: one header per go pulse
// Notes: idle header lines toggle
`timescale 1ns/1ps
`default_nettype none
module arf_node_model (
    input wire logic aclk,
    input wire logic go,
    input wire logic [9:0] g_bus,
    input wire logic [5:0] g_node,
    output logic req_valid,
    output logic req_to_physical,
    output logic [9:0] req_src_bus,
    output logic [5:0] req_src_node
);
    // ====================
    // Header launch, inverted while idle
    initial {req_valid, req_to_physical, req_src_bus, req_src_node} = 18'h0;
    always @(posedge aclk) begin
        req_valid <= go;
        req_to_physical <= go ? g_node[0] : ~req_to_physical;
        req_src_bus <= go ? g_bus : ~req_src_bus;
        req_src_node <= go ? g_node : ~req_src_node;
    end
endmodule
`default_nettype wire

// >>> tb_top.sv
// Purpose: filter bench
// Assumes: AXI4-Lite master tasks, node model
// Notes: one request and filter setup, then table, then hand cases
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk = 1'h0, rstn = 1'h0, go = 1'h0, awv = 1'h0, wv = 1'h0, bry = 1'h0, arv = 1'h0, rry = 1'h0;
    logic awr, wr, bv, arr, rv, qv, qp, cv, ca, ck, cq, cr, ta, tw, tr, tb, tv;
    logic [11:0] ad = 12'h000;
    logic [3:0] ws = 4'hF;
    logic [31:0] wd = 32'h0, rd;
    logic [9:0] gb = 10'h000, qb;
    logic [5:0] gn = 6'h00, qn;
    logic [1:0] br, rr;
    int n_mismatch = 0, cmp_count = 0;
    logic [17:0] rows [7] = '{{10'h3FF, 6'h3E, 2'h3}, {10'h005, 6'h3E, 2'h3}, {10'h3FF, 6'h3D, 2'h1},
        {10'h3FF, 6'h20, 2'h1}, {10'h3FF, 6'h1F, 2'h0}, {10'h3FF, 6'h3F, 2'h0}, {10'h012, 6'h05, 2'h3}};
    // ====================
    // Clock, design, node model
    always #12.5 clk = ~clk;
    arf_top DUT (.aclk(clk), .aresetn(rstn), .s_axi_awaddr(ad), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br),
        .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ad), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .local_bus(10'h005),
        .req_valid(qv), .req_to_physical(qp), .req_src_bus(qb), .req_src_node(qn), .chk_valid(cv),
        .chk_accept(ca), .chk_ack(ck), .chk_queue(cq), .chk_in_range(cr));
    arf_node_model u_node (.aclk(clk), .go(go), .g_bus(gb), .g_node(gn), .req_valid(qv),
        .req_to_physical(qp), .req_src_bus(qb), .req_src_node(qn));
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) $display("Error %s expected %h seen %h", what, exp, got);
        if (got !== exp) n_mismatch++;
    endtask
    // One AXI4-Lite write or read, answer checked
    task automatic axi(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge clk);
        ad <= a;
        wd <= d;
        {awv, wv, bry, arv, rry} <= {w, w, w, !w, !w};
        {tb, tv} = 2'h0;
        for (n = 0; !tb && !tv && n < 99; n++) begin
            @(negedge clk);
            {ta, tw, tr, tb, tv} = {awv && awr, wv && wr, arv && arr, bv && bry, rv && rry};
            if (tb || tv) check("resp", {30'h0, er}, {30'h0, tb ? br : rr});
            if (tv) check("rdata", d, rd);
            @(posedge clk);
            {awv, wv, arv, bry, rry} <= {awv && !ta, wv && !tw, arv && !tr, bry && !tb, rry && !tv};
        end
        if (!tb && !tv) check("axi_wait", 32'h1, 32'h0);
    endtask
    // One request header, verdict checked
    task automatic req(input logic [17:0] r);
        {gb, gn, go} <= {r[17:2], 1'h1};
        @(posedge clk);
        go <= 1'h0;
        @(posedge clk);
        @(negedge clk);
        check("verdict", {27'h0, 1'h1, {3{r[1]}}, r[0]}, {27'h0, cv, ca, ck, cq, cr});
        @(posedge clk);
    endtask
    task automatic test_done;
        if (n_mismatch == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // ====================
    // Main sequence
    initial begin
        repeat (6) @(posedge clk);
        rstn <= 1'h1;
        axi(1'h0, 12'h100, 32'h0, 2'h0);
        req({10'h012, 6'h05, 2'h1});
        axi(1'h1, 12'h100, 32'hC0000001, 2'h0);
        axi(1'h1, 12'h104, 32'h00000001, 2'h0);
        axi(1'h1, 12'h100, 32'h00000000, 2'h0);
        axi(1'h0, 12'h104, 32'hC0000000, 2'h0);
        foreach (rows[i]) req(rows[i]);
        axi(1'h1, 12'h104, 32'h80000000, 2'h0);
        req({10'h012, 6'h05, 2'h1});
        axi(1'h1, 12'h100, 32'h00000001, 2'h0);
        req({10'h3FF, 6'h20, 2'h3});
        axi(1'h0, 12'h108, 32'h00000004, 2'h0);
        ws <= 4'h8;
        axi(1'h1, 12'h104, 32'hFFFFFFFF, 2'h0);
        ws <= 4'hF;
        axi(1'h0, 12'h100, 32'h00000001, 2'h0);
        axi(1'h1, 12'h10C, 32'h0, 2'h2);
        axi(1'h0, 12'h10C, 32'h0, 2'h2);
        rstn <= 1'h0;
        repeat (2) @(posedge clk);
        rstn <= 1'h1;
        axi(1'h0, 12'h100, 32'h0, 2'h0);
        axi(1'h0, 12'h108, 32'h0, 2'h0);
        test_done();
    end
    initial begin
        #50000;
        n_mismatch++;
        test_done();
    end
endmodule
`default_nettype wire
